//--- via_pkg.sv
package via_pkg;

  // ---------------------------------------------------------------
  // widths, opcodes and fixed addresses
  // ---------------------------------------------------------------
  localparam int VIA_PC_W = 15;
  localparam int VIA_NSRC = 12;
  localparam logic [7:0] VIA_TRAP_OPCODE = 8'h00;
  localparam logic [7:0] VIA_BLOCK_LAST = 8'hFF;
  localparam logic [7:0] VIA_STACK_LIMIT = 8'h6F;
  localparam logic [14:0] VIA_ACK_PC = 15'h00FF;
  localparam logic [14:0] VIA_OVERPOP_PC = 15'h7FFF;
  localparam logic [14:0] VIA_ONE = 15'h0001;

  // ---------------------------------------------------------------
  // vector table low bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] VIA_VEC_TRAP = 8'hFE;
  localparam logic [7:0] VIA_VEC_NMI_RSVD = 8'hFC;
  localparam logic [7:0] VIA_VEC_RSVD = 8'hF0;
  localparam logic [7:0] VIA_VEC_DEFAULT = 8'hE0;
  // index 0 is the lowest-ranked maskable source (port wake-up)
  localparam logic [7:0] VIA_SRC_VEC [VIA_NSRC] = '{
    8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC,
    8'hEE, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA
  };

  // ---------------------------------------------------------------
  // timing counts (instruction cycles)
  // ---------------------------------------------------------------
  localparam logic [2:0] VIA_ACK_CYCLES = 3'h7;
  localparam logic [2:0] VIA_ACK_LAST = VIA_ACK_CYCLES - 3'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ext_irq_pin;
    logic idle_timer;
    logic timer1_a_request;
    logic timer1_b_request;
    logic serial_busy_low;
    logic usart_rx;
    logic usart_tx;
    logic timer2_a_request;
    logic timer2_b_request;
    logic timer3_a_request;
    logic timer3_b_request;
    logic port_wake;
  } via_src_t;

  typedef struct packed {
    logic valid;
    logic blank;
    logic [14:0] addr;
    logic [7:0] data;
  } via_fetch_t;

  typedef struct packed {
    logic valid;
    logic [14:0] addr;
    logic [7:0] opcode;
  } via_ir_t;

  typedef struct packed {
    logic valid;
    logic [14:0] addr;
  } via_addr_t;

  typedef enum logic [2:0] {
    VIA_IDLE = 3'b000,
    VIA_VIS_HI = 3'b001,
    VIA_VIS_LO = 3'b011,
    VIA_VIS_FIN = 3'b010,
    VIA_ACK = 3'b110
  } via_st_t;

  typedef struct packed {
    via_st_t st;
    logic [2:0] cnt;
    via_ir_t ir;
    via_addr_t pc;
    via_addr_t push;
    via_addr_t tbl;
    logic gie_clear;
    logic busy;
    logic [7:0] vis_byte;
    logic [6:0] vec_hi;
  } via_state_t;

  typedef struct packed {
    logic pending;
  } via_flag_t;

endpackage

//--- via_prio_enc.sv
`timescale 1ns/1ps
module via_prio_enc
  import via_pkg::*;
(
  // request state
  input wire logic trap,
  input wire via_src_t src_en,
  input wire via_src_t src_pend,
  // result
  output logic any_active,
  output logic [7:0] vec_byte
);

  // ---------------------------------------------------------------
  // ranking
  // ---------------------------------------------------------------
  logic [VIA_NSRC-1:0] active;

  assign active = src_en & src_pend;
  assign any_active = |active;

  // later, higher-ranked hits overwrite earlier ones
  always_comb begin
    vec_byte = VIA_VEC_DEFAULT;
    for (int i = 0; i < VIA_NSRC; i++) begin
      if (active[i]) begin
        vec_byte = VIA_SRC_VEC[i];
      end
    end
    if (trap) begin
      vec_byte = VIA_VEC_TRAP;
    end
  end

endmodule

//--- via_trap_flag.sv
`timescale 1ns/1ps
module via_trap_flag
  import via_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // events
  input wire logic set,
  input wire logic clr,
  // state
  output logic pending
);

  // ---------------------------------------------------------------
  // single hidden bit, not a nesting count
  // ---------------------------------------------------------------
  via_flag_t q, d;

  // a trap in the same cycle as the clear instruction must not be lost
  always_comb begin
    d = q;
    if (clr) begin
      d.pending = 1'b0;
    end
    if (set) begin
      d.pending = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pending = q.pending;

endmodule

//--- via_arbiter.sv
`timescale 1ns/1ps
module via_arbiter
  import via_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // instruction fetch from program memory
  input wire via_fetch_t fetch,
  // sequencer requests
  input wire logic vis_start,
  input wire logic [14:0] vis_addr,
  input wire logic clear_trap_pending_instr,
  input wire logic instr_boundary,
  input wire logic [14:0] next_addr,
  input wire logic stack_pop,
  input wire logic [7:0] pop_sp,
  input wire logic [14:0] pop_addr,
  // interrupt sources
  input wire logic global_irq_enable,
  input wire via_src_t src_en,
  input wire via_src_t src_pend,
  // vector table read data, one cycle after the read strobe
  input wire logic [7:0] tbl_data,
  // to the core
  output via_ir_t ir,
  output via_addr_t pc_load,
  output via_addr_t push,
  output via_addr_t tbl_rd,
  output logic gie_clear,
  output logic busy,
  output logic [7:0] vis_byte,
  output logic trap_pending_flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  via_state_t q, d;
  logic any_active;
  logic [7:0] enc_byte;
  logic trap_hit;
  logic mask_req;
  logic start_trap;
  logic start_mask;
  logic [14:0] vis_next;
  logic [6:0] vis_page;

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  via_prio_enc u_enc (
    .trap(trap_pending_flag),
    .src_en(src_en),
    .src_pend(src_pend),
    .any_active(any_active),
    .vec_byte(enc_byte)
  );

  via_trap_flag u_flag (
    .mclk(mclk),
    .reset_n(reset_n),
    .set(start_trap),
    .clr(clear_trap_pending_instr),
    .pending(trap_pending_flag)
  );

  assign trap_hit = q.ir.valid && (q.ir.opcode == VIA_TRAP_OPCODE);
  // pending trap masks everything but another trap
  assign mask_req = global_irq_enable && any_active && !trap_pending_flag;
  assign start_trap = (q.st == VIA_IDLE) && trap_hit;
  assign start_mask = (q.st == VIA_IDLE) && !trap_hit && !vis_start && !stack_pop
                      && instr_boundary && mask_req;
  // address after the instruction: a select at xxFF moves to the next page
  assign vis_next = vis_addr + VIA_ONE;
  assign vis_page = vis_next[14:8];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.pc.valid = 1'b0;
    d.push.valid = 1'b0;
    d.tbl.valid = 1'b0;
    d.gie_clear = 1'b0;
    // instruction register: blank locations and the overpop address read as zero
    d.ir.valid = fetch.valid;
    if (fetch.valid) begin
      d.ir.addr = fetch.addr;
      if (fetch.blank || (fetch.addr == VIA_OVERPOP_PC)) begin
        d.ir.opcode = VIA_TRAP_OPCODE;
      end else begin
        d.ir.opcode = fetch.data;
      end
    end
    unique case (q.st)
      VIA_IDLE: begin
        if (trap_hit) begin
          // return lands on the trap opcode again
          d.st = VIA_ACK;
          d.cnt = '0;
          d.push.valid = 1'b1;
          d.push.addr = q.ir.addr;
          d.gie_clear = 1'b0;
        end else if (vis_start) begin
          d.vis_byte = enc_byte;
          d.pc.valid = 1'b1;
          d.pc.addr = {vis_page, enc_byte};
          d.tbl.valid = 1'b1;
          d.tbl.addr = {vis_page, enc_byte};
          d.st = VIA_VIS_HI;
        end else if (stack_pop) begin
          d.pc.valid = 1'b1;
          if (pop_sp > VIA_STACK_LIMIT) begin
            d.pc.addr = VIA_OVERPOP_PC;
          end else begin
            d.pc.addr = pop_addr;
          end
        end else if (instr_boundary && mask_req) begin
          d.st = VIA_ACK;
          d.cnt = '0;
          d.gie_clear = 1'b1;
          d.push.valid = 1'b1;
          d.push.addr = next_addr;
        end
      end
      VIA_ACK: begin
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == VIA_ACK_LAST) begin
          d.pc.valid = 1'b1;
          d.pc.addr = VIA_ACK_PC;
          d.st = VIA_IDLE;
        end
      end
      VIA_VIS_HI: begin
        // high byte sits at the even address, low byte next
        d.tbl.valid = 1'b1;
        d.tbl.addr = {q.tbl.addr[14:1], 1'b1};
        d.st = VIA_VIS_LO;
      end
      VIA_VIS_LO: begin
        d.vec_hi = tbl_data[6:0];
        d.st = VIA_VIS_FIN;
      end
      VIA_VIS_FIN: begin
        d.pc.valid = 1'b1;
        d.pc.addr = {q.vec_hi, tbl_data};
        d.st = VIA_IDLE;
      end
      default: begin
        d.st = VIA_IDLE;
      end
    endcase
    d.busy = (d.st != VIA_IDLE);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ir = q.ir;
  assign pc_load = q.pc;
  assign push = q.push;
  assign tbl_rd = q.tbl;
  assign gie_clear = q.gie_clear;
  assign busy = q.busy;
  assign vis_byte = q.vis_byte;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  logic vis_go;
  assign vis_go = (q.st == VIA_IDLE) && !trap_hit && vis_start;
  logic [VIA_NSRC-1:0] act_vec;
  assign act_vec = src_en & src_pend;

  property p_vis_even;
    vis_go |=> pc_load.valid && !pc_load.addr[0] && (pc_load.addr[7:0] >= VIA_VEC_DEFAULT);
  endproperty
  a_vis_even: assert property (p_vis_even) else $error("vector byte not even in range");

  property p_vis_page;
    vis_go |=> pc_load.addr[14:8] == $past(vis_page);
  endproperty
  a_vis_page: assert property (p_vis_page) else $error("vector page wrong");

  property p_vis_default;
    vis_go && !any_active && !trap_pending_flag |=> vis_byte == VIA_VEC_DEFAULT;
  endproperty
  a_vis_default: assert property (p_vis_default) else $error("default entry missed");

  property p_vis_trap;
    vis_go && trap_pending_flag |=> vis_byte == VIA_VEC_TRAP;
  endproperty
  a_vis_trap: assert property (p_vis_trap) else $error("trap entry not chosen");

  property p_vis_load;
    vis_go |-> ##4 pc_load.valid && (pc_load.addr[7:0] == $past(tbl_data))
                   && (pc_load.addr[14:8] == $past(tbl_data[6:0], 2));
  endproperty
  a_vis_load: assert property (p_vis_load) else $error("vector not loaded");

  property p_flag_set;
    start_trap |=> trap_pending_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("trap flag not set");

  property p_flag_hold;
    trap_pending_flag && !clear_trap_pending_instr |=> trap_pending_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("trap flag lost");

  property p_ack_len;
    start_mask |=> gie_clear ##0 (busy && !pc_load.valid)[*6] ##1
                   (pc_load.valid && pc_load.addr == VIA_ACK_PC);
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("acknowledge timing wrong");

  property p_trap_push;
    start_trap |=> push.valid && !gie_clear && (push.addr == $past(q.ir.addr));
  endproperty
  a_trap_push: assert property (p_trap_push) else $error("trap push wrong");

  property p_mask_block;
    trap_pending_flag |=> !gie_clear;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("maskable taken under trap");

  property p_blank_zero;
    fetch.valid && fetch.blank |=> ir.valid && (ir.opcode == VIA_TRAP_OPCODE);
  endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("blank fetch not zero");

  property p_vis_rd_hi;
    vis_go |=> busy && tbl_rd.valid && !tbl_rd.addr[0];
  endproperty
  a_vis_rd_hi: assert property (p_vis_rd_hi) else $error("high byte read missing");

  property p_vis_rd_lo;
    vis_go |-> ##2 tbl_rd.valid && tbl_rd.addr[0]
                   && (tbl_rd.addr[14:1] == $past(tbl_rd.addr[14:1]));
  endproperty
  a_vis_rd_lo: assert property (p_vis_rd_lo) else $error("low byte read missing");

  property p_vis_pin;
    vis_go && !trap_pending_flag && act_vec[VIA_NSRC-1]
      |=> vis_byte == VIA_SRC_VEC[VIA_NSRC-1];
  endproperty
  a_vis_pin: assert property (p_vis_pin) else $error("pin entry not chosen");

  property p_vis_idle;
    vis_go && !trap_pending_flag && ((act_vec >> 10) == 12'h001)
      |=> vis_byte == VIA_SRC_VEC[10];
  endproperty
  a_vis_idle: assert property (p_vis_idle) else $error("idle timer entry wrong");

  property p_vis_serial;
    vis_go && !trap_pending_flag && ((act_vec >> 7) == 12'h001)
      |=> vis_byte == VIA_SRC_VEC[7];
  endproperty
  a_vis_serial: assert property (p_vis_serial) else $error("serial entry wrong");

  property p_vis_wake;
    vis_go && !trap_pending_flag && (act_vec == 12'h001)
      |=> vis_byte == VIA_SRC_VEC[0];
  endproperty
  a_vis_wake: assert property (p_vis_wake) else $error("wake entry wrong");

  property p_ir_overpop;
    fetch.valid && (fetch.addr == VIA_OVERPOP_PC)
      |=> ir.valid && (ir.opcode == VIA_TRAP_OPCODE);
  endproperty
  a_ir_overpop: assert property (p_ir_overpop) else $error("overpop fetch not zero");

  property p_ir_pass;
    fetch.valid && !fetch.blank && (fetch.addr != VIA_OVERPOP_PC)
      |=> ir.valid && (ir.addr == $past(fetch.addr)) && (ir.opcode == $past(fetch.data));
  endproperty
  a_ir_pass: assert property (p_ir_pass) else $error("fetched byte not passed");

  property p_pop_over;
    (q.st == VIA_IDLE) && !trap_hit && !vis_start && stack_pop && (pop_sp > VIA_STACK_LIMIT)
      |=> pc_load.valid && (pc_load.addr == VIA_OVERPOP_PC);
  endproperty
  a_pop_over: assert property (p_pop_over) else $error("overpop not caught");

  property p_flag_clr;
    clear_trap_pending_instr && !start_trap |=> !trap_pending_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_trap_len;
    start_trap |=> (busy && !gie_clear)[*6] ##1
                   (pc_load.valid && (pc_load.addr == VIA_ACK_PC) && !busy);
  endproperty
  a_trap_len: assert property (p_trap_len) else $error("trap sequence wrong");

  property p_ack_push;
    start_mask |=> push.valid && (push.addr == $past(next_addr));
  endproperty
  a_ack_push: assert property (p_ack_push) else $error("return address wrong");

  property p_gie_src;
    gie_clear |-> $past(start_mask);
  endproperty
  a_gie_src: assert property (p_gie_src) else $error("enable cleared by trap");

  property p_vis_hold;
    !vis_go |=> vis_byte == $past(vis_byte);
  endproperty
  a_vis_hold: assert property (p_vis_hold) else $error("vector byte changed");

  property p_pg_next;
    vis_go && (vis_addr[7:0] == VIA_BLOCK_LAST)
      |=> pc_load.addr[14:8] == $past(vis_addr[14:8]) + 7'h1;
  endproperty
  a_pg_next: assert property (p_pg_next) else $error("next block not used");

  property p_pg_same;
    vis_go && (vis_addr[7:0] != VIA_BLOCK_LAST)
      |=> pc_load.addr[14:8] == $past(vis_addr[14:8]);
  endproperty
  a_pg_same: assert property (p_pg_same) else $error("same block not used");

endmodule

//--- via_pmem_model.sv
`timescale 1ns/1ps
module via_pmem_model
  import via_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // vector table read
  input wire via_addr_t tbl_rd,
  output logic [7:0] tbl_data
);
  // ----------------------------------------
  // program memory, one cycle read latency
  // ----------------------------------------
  // byte is a scramble of its address so hi and lo bytes differ
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tbl_data <= 8'h00;
    end else if (tbl_rd.valid) begin
      tbl_data <= tbl_rd.addr[7:0] ^ 8'hA5;
    end else begin
      // no stale byte between reads
      tbl_data <= ~tbl_data;
    end
  end
endmodule

//--- vectored_interrupt_arbiter_tb_top.sv
`timescale 1ns/1ps
module vectored_interrupt_arbiter_tb_top
  import via_pkg::*;
;
  logic mclk;
  logic reset_n;
  via_fetch_t fetch;
  logic vis_start;
  logic [14:0] vis_addr;
  logic clear_trap_pending_instr;
  logic instr_boundary;
  logic [14:0] next_addr;
  logic stack_pop;
  logic [7:0] pop_sp;
  logic [14:0] pop_addr;
  logic global_irq_enable;
  via_src_t src_en;
  via_src_t src_pend;
  logic [7:0] tbl_data;
  via_ir_t ir;
  via_addr_t pc_load, push, tbl_rd;
  logic gie_clear, busy, trap_pending_flag;
  logic [7:0] vis_byte;
  int n_fail;
  int compares;
  int cycles;

  via_arbiter u_dut (
    .mclk(mclk), .reset_n(reset_n), .fetch(fetch), .vis_start(vis_start),
    .vis_addr(vis_addr), .clear_trap_pending_instr(clear_trap_pending_instr),
    .instr_boundary(instr_boundary), .next_addr(next_addr), .stack_pop(stack_pop),
    .pop_sp(pop_sp), .pop_addr(pop_addr), .global_irq_enable(global_irq_enable),
    .src_en(src_en), .src_pend(src_pend), .tbl_data(tbl_data), .ir(ir),
    .pc_load(pc_load), .push(push), .tbl_rd(tbl_rd), .gie_clear(gie_clear),
    .busy(busy), .vis_byte(vis_byte), .trap_pending_flag(trap_pending_flag)
  );

  via_pmem_model u_pmem (
    .mclk(mclk), .reset_n(reset_n), .tbl_rd(tbl_rd), .tbl_data(tbl_data)
  );

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic do_vis(input logic [14:0] a, input logic [7:0] b);
    logic [14:0] t;
    logic [7:0] hi;
    logic [7:0] lo;
    t = a + 15'h0001;
    t = {t[14:8], b};
    hi = t[7:0] ^ 8'hA5;
    lo = (t[7:0] | 8'h01) ^ 8'hA5;
    vis_addr = a;
    vis_start = 1'b1;
    tick(1);
    vis_start = 1'b0;
    chk(vis_byte, b);
    chk(pc_load.valid, 1'b1);
    chk(pc_load.addr, t);
    chk(tbl_rd.valid, 1'b1);
    chk(tbl_rd.addr, t);
    tick(1);
    chk(tbl_rd.addr, t | 15'h0001);
    tick(2);
    chk(pc_load.valid, 1'b1);
    chk(pc_load.addr, {hi[6:0], lo});
  endtask

  task automatic trap_seq(input logic [14:0] a, input logic [7:0] d, input logic bl);
    fetch = '{1'b1, bl, a, d};
    tick(1);
    fetch.valid = 1'b0;
    chk(ir.opcode, 8'h00);
    chk(ir.addr, a);
    tick(1);
    chk(busy, 1'b1);
    chk(push.valid, 1'b1);
    chk(push.addr, a);
    chk(trap_pending_flag, 1'b1);
    chk(gie_clear, 1'b0);
    tick(6);
    chk(pc_load.valid, 1'b1);
    chk(pc_load.addr, VIA_ACK_PC);
    chk(busy, 1'b0);
  endtask

  task automatic ack(input logic exp);
    global_irq_enable = 1'b1;
    next_addr = 15'h0456;
    instr_boundary = 1'b1;
    tick(1);
    instr_boundary = 1'b0;
    global_irq_enable = 1'b0;
    chk(gie_clear, exp);
    chk(push.valid, exp);
    if (exp) begin
      chk(push.addr, 15'h0456);
      tick(6);
      chk(pc_load.valid, 1'b1);
      chk(pc_load.addr, VIA_ACK_PC);
    end
  endtask

  task automatic pop(input logic [7:0] sp, input logic [14:0] exp);
    pop_sp = sp;
    pop_addr = 15'h0321;
    stack_pop = 1'b1;
    tick(1);
    stack_pop = 1'b0;
    chk(pc_load.valid, 1'b1);
    chk(pc_load.addr, exp);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    fetch = '0;
    vis_start = 1'b0;
    vis_addr = '0;
    clear_trap_pending_instr = 1'b0;
    instr_boundary = 1'b0;
    next_addr = '0;
    stack_pop = 1'b0;
    pop_sp = '0;
    pop_addr = '0;
    global_irq_enable = 1'b0;
    src_en = '0;
    src_pend = '1;
    tick(10);
    reset_n = 1'b1;
    tick(1);
    do_vis(15'h0150, 8'hE0);
    src_en = '1;
    src_pend = '0;
    do_vis(15'h01FF, 8'hE0);
    // each source wins over every lower one pending with it
    for (int i = 0; i < 12; i++) begin
      src_pend = via_src_t'((12'h002 << i) - 12'h001);
      do_vis(i[0] ? 15'h01FF : 15'h0150, 8'hE2 + 8'(2 * i) + (i >= 7 ? 8'h02 : 8'h00));
    end
    trap_seq(15'h0234, 8'h00, 1'b0);
    do_vis(15'h0150, 8'hFE);
    ack(1'b0);
    trap_seq(15'h0300, 8'h3C, 1'b1);
    clear_trap_pending_instr = 1'b1;
    tick(1);
    clear_trap_pending_instr = 1'b0;
    tick(1);
    chk(trap_pending_flag, 1'b0);
    ack(1'b1);
    pop(8'h70, VIA_OVERPOP_PC);
    pop(8'h6F, 15'h0321);
    trap_seq(15'h7FFF, 8'hFF, 1'b0);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(1);
    chk(trap_pending_flag, 1'b0);
    chk(busy, 1'b0);
    chk(vis_byte, 8'h00);
    results();
  end
endmodule
